// *** hdl/bvs_lane.sv ***
// one byte lane of the unsigned subtractor
// assumes op code from bvs_pkg; purely combinational
`default_nettype none

module bvs_lane
(
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  input  wire bvs_pkg::bvs_op_t   op,
  output logic      [7:0]         res,
  output logic                    borrow
);

  // nine-bit difference; bit 8 is the borrow
  wire logic [8:0] diff     = {1'b0, a} - {1'b0, b};
  wire logic [8:0] diff_rnd = diff + 9'h001;
  wire logic [7:0] wrap_v   = diff[7:0];
  wire logic [7:0] clamp_v  = diff[8] ? 8'h00 : diff[7:0];
  wire logic [7:0] halve_v  = diff[8:1];
  wire logic [7:0] hrnd_v   = diff_rnd[8:1];

  assign borrow = diff[8];
  assign res    = (op == bvs_pkg::BVS_OP_CLAMP)     ? clamp_v :
                  (op == bvs_pkg::BVS_OP_HALVE)     ? halve_v :
                  (op == bvs_pkg::BVS_OP_HALVE_RND) ? hrnd_v  : wrap_v;

endmodule

`default_nettype wire

// *** hdl/bvs_pkg.sv ***
// constants for the byte vector subtract and control field write block
// assumes a single 200 MHz core clock and an AHB-Lite slave for register access
//
// Summary of operation
// - wrapping subtract: each byte lane keeps low eight bits of a minus b
// - clamping subtract: a lane that would go below zero writes zero
// - wrap or clamp: any lane borrow sets control bit 20 to one
// - halving subtract: zero-extended nine-bit lane difference shifted right by one
// - rounding halving subtract adds one before the shift
// - halving forms leave the over/underflow flag field unchanged
// - no operation raises any operand-dependent exception
// - mask bits 0..5 each replace one control field from source bits
// - mask bits 6..9 have no effect
// - mask bit 1 selects size count field, control bits 12..7
// - mask bits 2..5 select bit 13, bits 23..16, bits 31..24, bit 14
// - single-operand control write acts as mask 0x1F
`default_nettype none

package bvs_pkg;

  // ***************************************************************
  // register map, byte addresses
  // ***************************************************************
  localparam logic [7:0] OPA_OFS    = 8'h00;
  localparam logic [7:0] OPB_OFS    = 8'h04;
  localparam logic [7:0] CMD_OFS    = 8'h08;
  localparam logic [7:0] RES_OFS    = 8'h0C;
  localparam logic [7:0] CTRL_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS   = 8'h14;
  localparam logic [7:0] MASK_OFS   = 8'h18;

  // ***************************************************************
  // command field: op in bits 2..0, mask in bits 13..4
  // ***************************************************************
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_MASK_LSB = 4;
  localparam int MASK_W       = 10;

  typedef enum logic [2:0] {
    BVS_OP_WRAP       = 3'b000,
    BVS_OP_CLAMP      = 3'b001,
    BVS_OP_HALVE      = 3'b010,
    BVS_OP_HALVE_RND  = 3'b011,
    BVS_OP_CTRL_WR    = 3'b100,
    BVS_OP_CTRL_WR1   = 3'b101
  } bvs_op_t;

  // ***************************************************************
  // control register fields
  // ***************************************************************
  localparam int          OUFLAG_BIT  = 20;
  localparam logic [9:0]  FULL_MASK   = 10'h01F;
  localparam logic [31:0] FLD0_BITS   = 32'h0000003F;
  localparam logic [31:0] FLD1_BITS   = 32'h00001F80;
  localparam logic [31:0] FLD2_BITS   = 32'h00002000;
  localparam logic [31:0] FLD3_BITS   = 32'h00FF0000;
  localparam logic [31:0] FLD4_BITS   = 32'hFF000000;
  localparam logic [31:0] FLD5_BITS   = 32'h00004000;
  localparam logic [31:0] CTRL_RESET  = 32'h00000000;

  // ***************************************************************
  // interrupt status bits
  // ***************************************************************
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_BORROW_BIT = 1;
  localparam int ST_W          = 2;

endpackage

`default_nettype wire

// *** hdl/bvs_top.sv ***
// byte vector subtract and control field write unit, AHB-Lite register slave
// assumes single word transfers, one clock, zero wait states
`default_nettype none

module bvs_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq
);

  // ***************************************************************
  // bus address phase capture
  // ***************************************************************
  logic       wr_q;
  logic       rd_q;
  logic [7:0] addr_q;

  wire logic take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q   <= take & hwrite;
      rd_q   <= take & ~hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // zero wait states, always okay; hsize is only ever a full word
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire logic wr_opa  = wr_q & (addr_q == bvs_pkg::OPA_OFS);
  wire logic wr_opb  = wr_q & (addr_q == bvs_pkg::OPB_OFS);
  wire logic wr_cmd  = wr_q & (addr_q == bvs_pkg::CMD_OFS);
  wire logic wr_ctrl = wr_q & (addr_q == bvs_pkg::CTRL_OFS);
  wire logic wr_stat = wr_q & (addr_q == bvs_pkg::STAT_OFS);
  wire logic wr_mask = wr_q & (addr_q == bvs_pkg::MASK_OFS);

  // ***************************************************************
  // operand, result and control state
  // ***************************************************************
  logic [31:0] opa_q;
  logic [31:0] opb_q;
  logic [31:0] res_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [bvs_pkg::ST_W-1:0] stat_q;
  logic [bvs_pkg::ST_W-1:0] stat_d;
  logic [bvs_pkg::ST_W-1:0] imask_q;

  // decode of the command word written this cycle
  wire bvs_pkg::bvs_op_t    op  =
    bvs_pkg::bvs_op_t'(hwdata[bvs_pkg::CMD_OP_LSB +: 3]);
  wire logic [bvs_pkg::MASK_W-1:0] cmd_mask = hwdata[bvs_pkg::CMD_MASK_LSB +: bvs_pkg::MASK_W];
  wire logic is_sub   = wr_cmd & ~op[2];
  wire logic is_ctl   = wr_cmd & (op == bvs_pkg::BVS_OP_CTRL_WR);
  wire logic is_ctl1  = wr_cmd & (op == bvs_pkg::BVS_OP_CTRL_WR1);
  wire logic is_flagd = is_sub & ~op[1];   // wrap or clamp only

  // ***************************************************************
  // four byte lanes
  // ***************************************************************
  logic [31:0] lane_res;
  logic [3:0]  lane_brw;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      bvs_lane u_lane
      (
        .a      (opa_q[8*gi +: 8]),
        .b      (opb_q[8*gi +: 8]),
        .op     (op),
        .res    (lane_res[8*gi +: 8]),
        .borrow (lane_brw[gi])
      );
    end
  endgenerate

  wire logic any_brw = |lane_brw;

  // ***************************************************************
  // masked control write
  // ***************************************************************
  // upper mask bits are simply never looked at
  wire logic [5:0] eff_mask = is_ctl1 ? bvs_pkg::FULL_MASK[5:0] : cmd_mask[5:0];
  wire logic [31:0] sel_bits =
      ({32{eff_mask[0]}} & bvs_pkg::FLD0_BITS)
    | ({32{eff_mask[1]}} & bvs_pkg::FLD1_BITS)
    | ({32{eff_mask[2]}} & bvs_pkg::FLD2_BITS)
    | ({32{eff_mask[3]}} & bvs_pkg::FLD3_BITS)
    | ({32{eff_mask[4]}} & bvs_pkg::FLD4_BITS)
    | ({32{eff_mask[5]}} & bvs_pkg::FLD5_BITS);
  wire logic [31:0] ctl_new = (ctrl_q & ~sel_bits) | (opa_q & sel_bits);

  // next control value; halving forms never touch the flag
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = hwdata;
    if (is_ctl | is_ctl1)
      ctrl_d = ctl_new;
    if (is_flagd & any_brw)
      ctrl_d[bvs_pkg::OUFLAG_BIT] = 1'b1;
  end

  // sticky events; a new event wins over the write-one clear
  always_comb
  begin
    stat_d = stat_q;
    if (wr_stat)
      stat_d = stat_q & ~hwdata[bvs_pkg::ST_W-1:0];
    if (wr_cmd)
      stat_d[bvs_pkg::ST_DONE_BIT] = 1'b1;
    if (is_flagd & any_brw)
      stat_d[bvs_pkg::ST_BORROW_BIT] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opa_q   <= 32'h00000000;
      opb_q   <= 32'h00000000;
      res_q   <= 32'h00000000;
      ctrl_q  <= bvs_pkg::CTRL_RESET;
      stat_q  <= '0;
      imask_q <= '0;
    end
    else
    begin
      if (wr_opa)
        opa_q <= hwdata;
      if (wr_opb)
        opb_q <= hwdata;
      if (is_sub)
        res_q <= lane_res;
      ctrl_q  <= ctrl_d;
      stat_q  <= stat_d;
      if (wr_mask)
        imask_q <= hwdata[bvs_pkg::ST_W-1:0];
    end
  end

  assign irq = |(stat_q & imask_q);

  // ***************************************************************
  // read data, unmapped reads return zero
  // ***************************************************************
  logic [31:0] rdata;
  always_comb
  begin
    case (addr_q)
      bvs_pkg::OPA_OFS:  rdata = opa_q;
      bvs_pkg::OPB_OFS:  rdata = opb_q;
      bvs_pkg::RES_OFS:  rdata = res_q;
      bvs_pkg::CTRL_OFS: rdata = ctrl_q;
      bvs_pkg::STAT_OFS: rdata = {30'h0, stat_q};
      bvs_pkg::MASK_OFS: rdata = {30'h0, imask_q};
      default:           rdata = 32'h00000000;
    endcase
  end
  assign hrdata = rd_q ? rdata : 32'h00000000;

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    (is_flagd & any_brw) |=> ctrl_q[bvs_pkg::OUFLAG_BIT];
  endproperty
  flag_set_a: assert property (p_flag_set) else $error("borrow did not set flag");

  property p_halve_keep;
    @(posedge hclk) disable iff (!hresetn)
    (is_sub & op[1] & ~wr_ctrl) |=>
      ctrl_q[bvs_pkg::OUFLAG_BIT] == $past(ctrl_q[bvs_pkg::OUFLAG_BIT]);
  endproperty
  halve_keep_a: assert property (p_halve_keep) else $error("halving changed flag");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (wr_cmd && op == bvs_pkg::BVS_OP_WRAP) |=>
      res_q[7:0] == 8'($past(opa_q[7:0]) - $past(opb_q[7:0]));
  endproperty
  wrap_res_a: assert property (p_wrap) else $error("wrap lane wrong");

  property p_clamp;
    @(posedge hclk) disable iff (!hresetn)
    (wr_cmd && op == bvs_pkg::BVS_OP_CLAMP && opa_q[15:8] < opb_q[15:8]) |=>
      res_q[15:8] == 8'h00;
  endproperty
  clamp_zero_a: assert property (p_clamp) else $error("clamp lane not zero");

  property p_halve;
    @(posedge hclk) disable iff (!hresetn)
    (wr_cmd && op == bvs_pkg::BVS_OP_HALVE) |=>
      res_q[31:24] == 8'(({1'b0, $past(opa_q[31:24])} - {1'b0, $past(opb_q[31:24])}) >> 1);
  endproperty
  halve_res_a: assert property (p_halve) else $error("halve lane wrong");

  property p_round;
    @(posedge hclk) disable iff (!hresetn)
    (wr_cmd && op == bvs_pkg::BVS_OP_HALVE_RND) |=>
      res_q[23:16] ==
      8'(({1'b0, $past(opa_q[23:16])} - {1'b0, $past(opb_q[23:16])} + 9'h001) >> 1);
  endproperty
  round_res_a: assert property (p_round) else $error("round lane wrong");

  property p_ctl_keep;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & ~cmd_mask[1]) |=> ctrl_q[12:7] == $past(ctrl_q[12:7]);
  endproperty
  ctl_keep_a: assert property (p_ctl_keep) else $error("unselected field changed");

  property p_ctl_scount;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & cmd_mask[1]) |=> ctrl_q[12:7] == $past(opa_q[12:7]);
  endproperty
  ctl_scount_a: assert property (p_ctl_scount) else $error("size count not written");

  property p_ctl_one;
    @(posedge hclk) disable iff (!hresetn)
    is_ctl1 |=> (ctrl_q[31:24] == $past(opa_q[31:24])) && (ctrl_q[15] == $past(ctrl_q[15]));
  endproperty
  ctl_one_a: assert property (p_ctl_one) else $error("single form not mask 0x1F");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (stat_q[0] & imask_q[0]) |-> irq;
  endproperty
  irq_level_a: assert property (p_irq) else $error("irq not raised");

  // bus steps: an address phase is taken, its data phase follows one cycle later
  sequence s_ctrl_addr;
    take & hwrite & (haddr[7:0] == bvs_pkg::CTRL_OFS);
  endsequence

  sequence s_res_addr;
    take & ~hwrite & (haddr[7:0] == bvs_pkg::RES_OFS);
  endsequence

  // a direct control write lands on the edge that closes its data phase
  property p_ctrl_direct;
    @(posedge hclk) disable iff (!hresetn)
    s_ctrl_addr ##1 1'b1 |=> ctrl_q == $past(hwdata);
  endproperty
  ctrl_direct_a: assert property (p_ctrl_direct) else $error("direct control write lost");

  // read data only stands in the data phase, so it is checked there
  property p_res_read;
    @(posedge hclk) disable iff (!hresetn)
    s_res_addr |=> hrdata == res_q;
  endproperty
  res_read_a: assert property (p_res_read) else $error("result read data wrong");

  // a mask with only upper bits set must leave the whole register alone
  property p_mask_none;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & (cmd_mask[5:0] == 6'h00)) |=> $stable(ctrl_q);
  endproperty
  mask_none_a: assert property (p_mask_none) else $error("upper mask bits changed control");

  property p_ctl_pos;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & cmd_mask[0]) |=> ctrl_q[5:0] == $past(opa_q[5:0]);
  endproperty
  ctl_pos_a: assert property (p_ctl_pos) else $error("position field not written");

  property p_ctl_bytes;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & cmd_mask[3]) |=> ctrl_q[23:16] == $past(opa_q[23:16]);
  endproperty
  ctl_bytes_a: assert property (p_ctl_bytes) else $error("byte field not written");

  property p_ctl_bit14;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl & cmd_mask[5]) |=> ctrl_q[14] == $past(opa_q[14]);
  endproperty
  ctl_bit14_a: assert property (p_ctl_bit14) else $error("bit 14 not written");

  // bits 6 and 15 belong to no field, so no mask may reach them
  property p_ctl_spare;
    @(posedge hclk) disable iff (!hresetn)
    (is_ctl | is_ctl1) |=> (ctrl_q[6] == $past(ctrl_q[6])) && (ctrl_q[15] == $past(ctrl_q[15]));
  endproperty
  ctl_spare_a: assert property (p_ctl_spare) else $error("spare control bit changed");

  // every command leaves a sticky done mark
  property p_done_set;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd |=> stat_q[bvs_pkg::ST_DONE_BIT];
  endproperty
  done_set_a: assert property (p_done_set) else $error("done status not set");

  // operand values never turn into a bus error
  property p_okay_resp;
    @(posedge hclk) disable iff (!hresetn)
    !hresp;
  endproperty
  okay_resp_a: assert property (p_okay_resp) else $error("error response seen");

endmodule

`default_nettype wire

// *** verification/bvs_host.sv ***
// bus master model for the byte vector subtract unit
// assumes one clock, single word transfers and one slave on the bus
`default_nettype none

module bvs_host
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hresp,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus until the first call
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // one single transfer; call right after a rising edge
  // no cycle count is assumed: the slave may stretch either phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    r = hresp;
  endtask
endmodule

`default_nettype wire

// *** verification/byte_vector_sub_ctrl_write_test.sv ***
// self-checking bench for the byte vector subtract unit
// assumes bvs_pkg and the bus master model bvs_host are compiled first
`default_nettype none

module byte_vector_sub_ctrl_write_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] old_v;
  logic [31:0] fld [10];
  int          miscompares;
  int          total_checks;

  // the one slave drives the bus ready
  bvs_top bvs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
  bvs_host bvs_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  always #2.5 hclk = ~hclk;

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        r;
    bvs_host_i.xfer({24'h0, a}, 1'b1, d, q, r);
  endtask

  // every read also checks that the response stays okay
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        r;
    bvs_host_i.xfer({24'h0, a}, 1'b0, 32'h0, q, r);
    check({31'h0, r}, 32'h0);
    check(q, exp);
  endtask

  // per-lane reference over a nine-bit difference
  function automatic logic [31:0] sub_exp(input logic [2:0] op, input logic [31:0] a,
                                          input logic [31:0] b);
    logic [8:0]  d;
    logic [31:0] y;
    y = 32'h0;
    for (int n = 0; n < 4; n++)
    begin
      d = {1'b0, a[8*n+:8]} - {1'b0, b[8*n+:8]};
      case (op)
        3'h0: y[8*n+:8] = d[7:0];
        3'h1: y[8*n+:8] = d[8] ? 8'h00 : d[7:0];
        3'h2: y[8*n+:8] = d[8:1];
        default: y[8*n+:8] = 8'(9'(d + 9'h001) >> 1);
      endcase
    end
    return y;
  endfunction

  function automatic logic [31:0] cmdw(input logic [2:0] op, input logic [9:0] m);
    return {18'h0, m, 1'b0, op};
  endfunction

  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ***************************************************************
  // tests
  // ***************************************************************
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    fld = '{bvs_pkg::FLD0_BITS, bvs_pkg::FLD1_BITS, bvs_pkg::FLD2_BITS, bvs_pkg::FLD3_BITS,
            bvs_pkg::FLD4_BITS, bvs_pkg::FLD5_BITS, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(bvs_pkg::CTRL_OFS, bvs_pkg::CTRL_RESET);
    // lanes: borrow by one, small borrow, diff one, worst borrow
    // halving sees the flag clear once, so a stray set shows, then preset, so a clear shows
    for (int k = 0; k < 4; k++)
    begin
      wr(bvs_pkg::CTRL_OFS, (k == 3) ? 32'h00100000 : 32'h0);
      wr(bvs_pkg::OPA_OFS, 32'h00FF1080);
      wr(bvs_pkg::OPB_OFS, 32'hFFFE2081);
      wr(bvs_pkg::CMD_OFS, cmdw(k[2:0], 10'h0));
      rd(bvs_pkg::RES_OFS, sub_exp(k[2:0], 32'h00FF1080, 32'hFFFE2081));
      rd(bvs_pkg::CTRL_OFS, (k == 2) ? 32'h0 : 32'h00100000);
    end
    // source is the inverse of the old value, so a replaced field flips
    old_v = 32'hC3C33C3C;
    wr(bvs_pkg::OPA_OFS, ~old_v);
    for (int i = 0; i < 10; i++)
    begin
      wr(bvs_pkg::CTRL_OFS, old_v);
      wr(bvs_pkg::CMD_OFS, cmdw(3'h4, 10'(10'h1 << i)));
      rd(bvs_pkg::CTRL_OFS, old_v ^ fld[i]);
    end
    wr(bvs_pkg::CTRL_OFS, old_v);
    wr(bvs_pkg::CMD_OFS, cmdw(3'h4, 10'h3C2));
    rd(bvs_pkg::CTRL_OFS, old_v ^ bvs_pkg::FLD1_BITS);
    wr(bvs_pkg::CTRL_OFS, old_v);
    wr(bvs_pkg::CMD_OFS, cmdw(3'h5, 10'h0));
    rd(bvs_pkg::CTRL_OFS, old_v ^ 32'hFFFF3FBF);
    // interrupt: borrow and done both sticky so far, raised while masked, unmasked, cleared
    rd(bvs_pkg::STAT_OFS, 32'h3);
    wr(bvs_pkg::STAT_OFS, 32'h3);
    wr(bvs_pkg::MASK_OFS, 32'h0);
    wr(bvs_pkg::CMD_OFS, 32'h6);
    rd(bvs_pkg::STAT_OFS, 32'h1);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(bvs_pkg::MASK_OFS, 32'h1);
    @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(bvs_pkg::STAT_OFS, 32'h1);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    rd(bvs_pkg::STAT_OFS, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'hF0, 32'h0);
    // reset in mid-run: control, result and mask all hold non-zero values here
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(bvs_pkg::CTRL_OFS, bvs_pkg::CTRL_RESET);
    rd(bvs_pkg::RES_OFS, 32'h0);
    rd(bvs_pkg::MASK_OFS, 32'h0);
    give_verdict;
  end

  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    give_verdict;
  end
endmodule

`default_nettype wire
